// file: lc_codec.sv
/*
  8b/10b codec: byte fifo, table encoder with running disparity, table decoder.
  assumes producer, serializer and deserializer logic on the same clock.
*/
`timescale 1ns/1ns

module lc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module lc_codec (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic [7:0]     tx_data,
  input  wire logic           tx_valid,
  output logic                tx_ready,
  output lc_pkg::lc_sym_t     sym_out,
  output logic                sym_out_valid,
  input  wire logic           sym_out_ready,
  input  wire lc_pkg::lc_sym_t sym_in,
  input  wire logic           sym_in_valid,
  output logic [7:0]          rx_data,
  output logic                rx_valid,
  output logic                rx_err
);
  // 5b/6b encode table, positive-disparity column
  function automatic logic [5:0] enc6(input logic [4:0] d);
    logic [5:0] c;
    case (d)
      5'h00: c = 6'h18;
      5'h01: c = 6'h22;
      5'h02: c = 6'h12;
      5'h03: c = 6'h31;
      5'h04: c = 6'h0a;
      5'h05: c = 6'h29;
      5'h06: c = 6'h19;
      5'h07: c = 6'h07;
      5'h08: c = 6'h06;
      5'h09: c = 6'h25;
      5'h0a: c = 6'h15;
      5'h0b: c = 6'h34;
      5'h0c: c = 6'h0d;
      5'h0d: c = 6'h2c;
      5'h0e: c = 6'h1c;
      5'h0f: c = 6'h28;
      5'h10: c = 6'h24;
      5'h11: c = 6'h23;
      5'h12: c = 6'h13;
      5'h13: c = 6'h32;
      5'h14: c = 6'h0b;
      5'h15: c = 6'h2a;
      5'h16: c = 6'h1a;
      5'h17: c = 6'h05;
      5'h18: c = 6'h0c;
      5'h19: c = 6'h26;
      5'h1a: c = 6'h16;
      5'h1b: c = 6'h09;
      5'h1c: c = 6'h0e;
      5'h1d: c = 6'h11;
      5'h1e: c = 6'h21;
      5'h1f: c = 6'h14;
      default: c = 6'h18;
    endcase
    return c;
  endfunction

  // 3b/4b encode table, positive-disparity column
  function automatic logic [3:0] enc4(input logic [2:0] d);
    logic [3:0] c;
    case (d)
      3'h0: c = 4'h4;
      3'h1: c = 4'h9;
      3'h2: c = 4'h5;
      3'h3: c = 4'h3;
      3'h4: c = 4'h2;
      3'h5: c = 4'ha;
      3'h6: c = 4'h6;
      3'h7: c = 4'h1;
      default: c = 4'h4;
    endcase
    return c;
  endfunction

  function automatic logic [2:0] ones6(input logic [5:0] c);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, c[i]};
    end
    return n;
  endfunction

  // choose group form for the current disparity; negative side flips unbalanced groups
  function automatic logic [5:0] pick6(input logic [5:0] c, input logic rd_pos);
    logic [5:0] r;
    r = c;
    if (!rd_pos) begin
      if (c == lc_pkg::G6_BAL_POS) begin
        r = lc_pkg::G6_BAL_NEG;
      end else if (ones6(c) != 3'h3) begin
        r = ~c;
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] pick4(input logic [3:0] c, input logic rd_pos);
    logic [3:0] r;
    r = c;
    if (!rd_pos) begin
      if (c == lc_pkg::G4_BAL_POS) begin
        r = lc_pkg::G4_BAL_NEG;
      end else if (ones6({2'h0, c}) != 3'h2) begin
        r = ~c;
      end
    end
    return r;
  endfunction

  // reverse lookup: any legal form of any entry, otherwise the marker
  function automatic logic [7:0] dec6(input logic [5:0] c);
    logic [7:0] r;
    r = lc_pkg::INVALID_CODE_MARKER;
    for (int i = 0; i < 32; i++) begin
      if (c == enc6(5'(i)) || c == pick6(enc6(5'(i)), 1'b0)) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] dec4(input logic [3:0] c);
    logic [7:0] r;
    r = lc_pkg::INVALID_CODE_MARKER;
    for (int i = 0; i < 8; i++) begin
      if (c == enc4(3'(i)) || c == pick4(enc4(3'(i)), 1'b0)) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  // transmit path
  logic [7:0]      fifo_data;
  logic            fifo_valid;
  logic            fifo_ready;
  lc_pkg::lc_sym_t sym_q;
  logic            sym_valid_q;
  logic            rd_pos_q;

  lc_fifo #(
    .WIDTH (lc_pkg::DATA_W),
    .DEPTH (lc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  wire [5:0] raw6   = enc6(fifo_data[4:0]);
  wire [3:0] raw4   = enc4(fifo_data[7:5]);
  wire [5:0] out6   = pick6(raw6, rd_pos_q);
  wire       rd_mid = rd_pos_q ^ (ones6(out6) != 3'h3);
  wire [3:0] out4   = pick4(raw4, rd_mid);
  wire       rd_end = rd_mid ^ (ones6({2'h0, out4}) != 3'h2);

  // a held symbol blocks the next byte, so back-pressure reaches the fifo
  assign fifo_ready = !sym_valid_q || sym_out_ready;
  wire   load       = fifo_valid && fifo_ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sym_q       <= lc_pkg::SYM_RESET;
      sym_valid_q <= 1'b0;
      rd_pos_q    <= lc_pkg::RD_RESET;
    end else begin
      if (load) begin
        sym_q       <= '{grp4: out4, grp6: out6};
        sym_valid_q <= 1'b1;
        rd_pos_q    <= rd_end;
      end else if (sym_out_ready) begin
        sym_valid_q <= 1'b0;
      end
    end
  end

  assign sym_out       = sym_q;
  assign sym_out_valid = sym_valid_q;

  // receive path
  wire [7:0] d5     = dec6(sym_in.grp6);
  wire [7:0] d3     = dec4(sym_in.grp4);
  wire       bad    = (d5 == lc_pkg::INVALID_CODE_MARKER)
                   || (d3 == lc_pkg::INVALID_CODE_MARKER);
  wire [7:0] joined = (d3 << 5) + d5;

  lc_pkg::lc_rx_t rx_q;
  logic           rx_valid_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_q       <= '{data: lc_pkg::DATA_RESET, err: 1'b0};
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= sym_in_valid && !bad;
      rx_q.err   <= sym_in_valid && bad;
      if (sym_in_valid && !bad) begin
        rx_q.data <= joined;
      end
    end
  end

  assign rx_data  = rx_q.data;
  assign rx_valid = rx_valid_q;
  assign rx_err   = rx_q.err;
endmodule

// file: lc_codec_assertions.sv
/* port checker for the line codec.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module lc_chk (
  input wire logic            clk,
  input wire logic            rst_b,
  input wire logic [7:0]      tx_data,
  input wire logic            tx_valid,
  input wire logic            tx_ready,
  input wire lc_pkg::lc_sym_t sym_out,
  input wire logic            sym_out_valid,
  input wire logic            sym_out_ready,
  input wire lc_pkg::lc_sym_t sym_in,
  input wire logic            sym_in_valid,
  input wire logic [7:0]      rx_data,
  input wire logic            rx_valid,
  input wire logic            rx_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic logic run6(logic [9:0] s);
    run6 = 1'b0;
    for (int i = 0; i < 5; i++) run6 |= (s[i+:6] == 6'h00) || (s[i+:6] == 6'h3f);
  endfunction
  sequence s_bad_in;
    sym_in_valid && sym_in.grp6 == 6'h00;
  endsequence
  sequence s_err_out;
    rx_err && !rx_valid;
  endsequence
  sequence s_stalled;
    sym_out_valid && !sym_out_ready;
  endsequence
  AST_ONE_PER_SYM: assert property (sym_in_valid |=> rx_valid != rx_err)
    else $error("one result per symbol expected");
  AST_NO_SYM_NO_OUT: assert property (!sym_in_valid |=> !rx_valid && !rx_err)
    else $error("result without a symbol");
  AST_BAD_GROUP: assert property (s_bad_in |=> s_err_out)
    else $error("zero group not flagged");
  AST_HOLD_SYM: assert property (s_stalled |=> sym_out_valid && $stable(sym_out))
    else $error("symbol dropped before accept");
  AST_BALANCE: assert property (sym_out_valid |-> $countones(sym_out) inside {[4:6]})
    else $error("symbol out of balance");
  AST_GRP6_BAL: assert property (sym_out_valid |-> $countones(sym_out.grp6) inside {[2:4]})
    else $error("six bit group out of balance");
  AST_RUN: assert property (sym_out_valid |-> !run6(sym_out))
    else $error("run of six equal bits");
  AST_RX_HOLD: assert property ($past(rst_b) && !rx_valid |-> rx_data == $past(rx_data))
    else $error("rx byte changed without valid");
  AST_EXCL: assert property (!(rx_valid && rx_err))
    else $error("valid and error together");
  AST_RST: assert property (disable iff (1'b0) !rst_b |=> tx_ready && !sym_out_valid
    && !rx_valid && !rx_err)
    else $error("outputs not reset");
endmodule
bind lc_codec lc_chk i_lc_chk (.clk(clk), .rst_b(rst_b), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .sym_out(sym_out), .sym_out_valid(sym_out_valid),
  .sym_out_ready(sym_out_ready), .sym_in(sym_in), .sym_in_valid(sym_in_valid),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err));

// file: lc_peer.sv
/* far-side model: takes symbols, echoes them back, tracks line disparity.
   assumes the codec's clock; stall and bad come from the bench. */
`timescale 1ns/1ns
module lc_peer (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire lc_pkg::lc_sym_t sym_out,
  input  wire logic            sym_out_valid,
  output logic                 sym_out_ready,
  input  wire logic            stall,
  input  wire logic            bad,
  output lc_pkg::lc_sym_t      sym_in,
  output logic                 sym_in_valid,
  output logic                 disp_bad
);
  int rd;
  assign sym_out_ready = !stall;
  always @(posedge clk) begin
    if (!rst_b) begin
      rd = 0;
      disp_bad <= 1'b0;
      sym_in <= '0;
      sym_in_valid <= 1'b0;
    end else if (sym_out_valid && sym_out_ready) begin
      rd = rd + 2 * $countones(sym_out) - 10;
      if (rd < 0 || rd > 2) disp_bad <= 1'b1;
      sym_in <= bad ? {sym_out.grp4, 6'h00} : sym_out;
      sym_in_valid <= 1'b1;
    end else begin
      sym_in <= ~sym_in; // last symbol and its complement alternate between symbols
      sym_in_valid <= 1'b0;
    end
  end
endmodule

// file: lc_pkg.sv
/*
  shared constants and carrier types of the table-driven 8b/10b line codec.
  assumes a single core clock; the package holds no logic.
*/
package lc_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned LOW_W       = 5;
  localparam int unsigned HIGH_W      = 3;
  localparam int unsigned GRP6_W      = 6;
  localparam int unsigned GRP4_W      = 4;
  localparam int unsigned SYM_W       = 10;
  localparam int unsigned FIFO_DEPTH  = 8;

  // decode table entries are bytes; this value is never a data group
  localparam logic [7:0]  INVALID_CODE_MARKER = 8'hff;
  // running disparity after reset: 0 means negative
  localparam logic        RD_RESET    = 1'b0;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [9:0]  SYM_RESET   = 10'h000;

  // special balanced groups that, unlike other balanced groups, swap to their plain complement on the negative side
  localparam logic [5:0]  G6_BAL_POS  = 6'h07;
  localparam logic [5:0]  G6_BAL_NEG  = 6'h38;
  localparam logic [3:0]  G4_BAL_POS  = 4'h3;
  localparam logic [3:0]  G4_BAL_NEG  = 4'hc;

  // line symbol; the serializer sends bit 0 first
  typedef struct packed {
    logic [3:0] grp4;
    logic [5:0] grp6;
  } lc_sym_t;

  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } lc_rx_t;
endpackage

// file: tb.sv
/* loopback bench: bytes in, symbols echoed back, bytes compared.
   assumes lc_pkg, lc_codec, lc_peer and the checker are compiled first. */
`timescale 1ns/1ns
module tb;
  logic            clk = 0;
  logic            rst_b = 0;
  logic [7:0]      tx_data = 8'h00;
  logic            tx_valid = 0;
  logic            hold = 0;
  logic            rnd_en = 0;
  logic            rnd_bit = 0;
  logic            bad = 0;
  logic            tx_ready, sym_out_valid, sym_out_ready, sym_in_valid;
  logic            rx_valid, rx_err, disp_bad;
  logic [7:0]      rx_data;
  lc_pkg::lc_sym_t sym_out, sym_in;
  int              err_count = 0;
  int              comparisons = 0;
  logic [9:0]      exp_q[$];
  logic [9:0]      note;
  always #5 clk = ~clk;
  always @(posedge clk) rnd_bit <= 1'($urandom);
  lc_codec i_lc_codec (.clk(clk), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .sym_out(sym_out), .sym_out_valid(sym_out_valid),
    .sym_out_ready(sym_out_ready), .sym_in(sym_in), .sym_in_valid(sym_in_valid),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err));
  lc_peer i_lc_peer (.clk(clk), .rst_b(rst_b), .sym_out(sym_out), .sym_out_valid(sym_out_valid),
    .sym_out_ready(sym_out_ready), .stall(hold | (rnd_en & rnd_bit)), .bad(bad),
    .sym_in(sym_in), .sym_in_valid(sym_in_valid), .disp_bad(disp_bad));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("ERROR %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    int n;
    n = 0;
    exp_q.push_back({~e, e, e ? 8'h00 : b});
    tx_data <= b;
    tx_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 300);
    if (tx_ready !== 1'b1) give_up();
    @(posedge clk);
  endtask
  task automatic drain(input int t);
    int n;
    n = 0;
    tx_valid <= 1'b0;
    while (exp_q.size() != 0 && n < 900) begin
      @(posedge clk);
      n++;
    end
    if (n >= 900) give_up();
    repeat (2) @(posedge clk);
    $display("test %0d done", t);
  endtask
  // each result takes the oldest note; a stray result meets 0 and fails
  // an unknown pulse is checked too, so it cannot slip through
  always @(negedge clk) begin
    if (rst_b && (rx_valid !== 1'b0 || rx_err !== 1'b0)) begin
      note = exp_q.size() ? exp_q.pop_front() : 10'h000;
      check({rx_valid, rx_err, rx_err ? 8'h00 : rx_data}, note);
    end
  end
  initial begin
    int i;
    int cnt;
    void'($urandom(49672));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    hold <= 1'b1;
    send(8'h00, 1'b0);
    tx_valid <= 1'b0;
    i = 0;
    while (sym_out_valid !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (sym_out_valid !== 1'b1) give_up();
    // disparity starts negative: the 6-bit entry goes out inverted, the 4-bit one as is
    check(sym_out, {4'h4, ~6'h18});
    @(posedge clk);
    hold <= 1'b0;
    drain(1);
    rnd_en <= 1'b1;
    for (i = 0; i < 256; i++) send(i[7:0], 1'b0);
    drain(2);
    rnd_en <= 1'b0;
    hold <= 1'b1;
    cnt = 0;
    for (i = 0; i < 12; i++) begin
      tx_data <= 8'($urandom);
      tx_valid <= 1'b1;
      @(negedge clk);
      if (tx_ready === 1'b1) begin
        exp_q.push_back({2'h2, tx_data});
        cnt++;
      end
      @(posedge clk);
    end
    // a stalled line holds one symbol and a full fifo behind it
    check(10'(cnt), 10'(lc_pkg::FIFO_DEPTH + 1));
    hold <= 1'b0;
    drain(3);
    bad <= 1'b1;
    send(8'h5a, 1'b1);
    drain(4);
    bad <= 1'b0;
    send(8'ha5, 1'b0);
    drain(5);
    check({9'h000, disp_bad}, 10'h000);
    stop_test();
  end
endmodule
